/* File: core/disk_port_pkg.sv */
// constants and carrier types for the drive-port controller
// assumes a 20 MHz clock and active-low drive cable signalling
package disk_port_pkg;

  // *****************************************************
  // timing
  // *****************************************************
  localparam int CLK_HZ         = 20_000_000;
  localparam int STEP_PULSE_NS  = 1000;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int STEP_GAP_NS    = 3000;
  localparam int STEP_GAP_CYC   = (STEP_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CNT_W          = 8;
  localparam logic [CNT_W-1:0] PULSE_CNT = CNT_W'(STEP_PULSE_CYC);
  localparam logic [CNT_W-1:0] GAP_CNT   = CNT_W'(STEP_GAP_CYC);
  localparam logic [3:0] HEAD_MAX = 4'hE;

  // *****************************************************
  // carriers
  // *****************************************************
  typedef struct packed {
    logic       readyN;
    logic       seekDoneN;
    logic       trackZeroN;
    logic       faultN;
    logic       indexN;
    logic       selectedN;
  } fixedStat_t;

  typedef struct packed {
    logic       readyN;
    logic       trackZeroN;
    logic       protectN;
    logic       indexN;
  } floppyStat_t;

  typedef struct packed {
    logic       floppy;   // 1 = floppy port, 0 = fixed port
    logic [1:0] unit;     // drive number minus one
    logic       enable;   // select a drive at all
    logic [3:0] head;     // fixed-drive head
    logic       side;     // floppy side
    logic       motorOn;  // floppy spindle
  } driveCfg_t;

  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_GAP} stepState_t;

endpackage : disk_port_pkg

/* File: core/disk_port_ctrl.sv */
// drive-side controller for one fixed-disk port and one floppy port
// assumes drive status inputs are synchronous to clk; user side is
// a simple level/strobe interface from the disk sequencer
`timescale 1ns/1ps

// Summary of operation
// - fixed drive pulls seek-settled low when heads settle
// - fixed drive outer-cylinder line low exactly at cylinder zero
// - fault low inhibits writes and steps; deselecting clears it
// - fixed track-start pulses every revolution; only falling edge counts
// - fixed step moves heads; direction high outward, low inward
// - floppy index pulse once per revolution, about 200 ms
// - floppy direction high away from centre, low toward it
// - floppy drive flags track zero on its outer-track line
// - floppy protection line low while diskette is write protected
// - floppy ready only with diskette in and motor at speed
// - fixed drive answers selected only at its programmed number
module disk_port_ctrl (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // user side
  input  wire disk_port_pkg::driveCfg_t    cfg,
  input  wire logic                        stepReq,
  input  wire logic                        stepOut,
  input  wire logic                        writeReq,
  input  wire logic                        writeBit,
  output logic                             stepBusy,
  output logic                             driveUsable,
  output logic                             writeActive,
  output logic                             indexPulse,
  output logic                             fluxPulse,
  output logic                             atTrackZero,
  output logic                             faultSeen,
  // fixed drive cable
  input  wire disk_port_pkg::fixedStat_t   fixStat,
  output logic                             fixWriteGateN,
  output logic                             fixStepN,
  output logic                             fixDirIn,
  output logic [1:0]                       fixSelectN,
  output logic [3:0]                       fixHeadN,
  output logic                             mfmWrPlus,
  output logic                             mfmWrMinus,
  input  wire logic                        mfmRdPlus,
  input  wire logic                        mfmRdMinus,
  // floppy cable
  input  wire disk_port_pkg::floppyStat_t  flpStat,
  input  wire logic                        flpReadData,
  output logic [3:0]                       flpSelectN,
  output logic                             flpMotorN,
  output logic                             flpDir,
  output logic                             flpStepN,
  output logic                             flpWriteDataN,
  output logic                             flpWriteGateN,
  output logic                             flpSideN
);
  import disk_port_pkg::*;

  // *****************************************************
  // helpers
  // *****************************************************
  // one-hot active-low select; only one line can ever be low
  function automatic logic [3:0] sel_decode(input logic en, input logic [1:0] u);
    logic [3:0] s;
    s = 4'hF;
    if (en)
      s[u] = 1'b0;
    return s;
  endfunction

  // *****************************************************
  // status qualification
  // *****************************************************
  logic fixSel;
  logic ready;
  logic inhibit;
  logic idxPrev_q;
  logic idxPrev_d;
  logic rdPrev_q;
  logic rdPrev_d;
  logic [3:0] fixSelAll;

  // the fixed port only has two select lines, so units 2 and 3 pick nothing there
  assign fixSel    = cfg.enable && !cfg.floppy && !cfg.unit[1];
  assign fixSelAll = sel_decode(fixSel, cfg.unit);

  // ready, settled and selected all needed for the fixed drive
  always_comb
  begin
    if (!cfg.enable)
      ready = 1'b0;
    else if (cfg.floppy)
      ready = !flpStat.readyN;
    else
      ready = !fixStat.readyN && !fixStat.seekDoneN && !fixStat.selectedN;
  end

  // fault or protect blocks motion and recording
  always_comb
  begin
    if (cfg.floppy)
      inhibit = !flpStat.protectN;
    else
      inhibit = !fixStat.faultN;
  end

  // *****************************************************
  // step sequencer
  // *****************************************************
  stepState_t       st_q;
  stepState_t       st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             dir_q;
  logic             dir_d;

  // direction is set on the same edge the pulse starts and held through the gap
  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    dir_d = dir_q;
    case (st_q)
      ST_IDLE:
      begin
        if (stepReq && ready && !inhibit)
        begin
          st_d  = ST_PULSE;
          cnt_d = PULSE_CNT;
          dir_d = stepOut;
        end
      end
      ST_PULSE:
      begin
        if (cnt_q <= 1)
        begin
          st_d  = ST_GAP;
          cnt_d = GAP_CNT;
        end
        else
          cnt_d = cnt_q - 1'b1;
      end
      ST_GAP:
      begin
        if (cnt_q <= 1)
          st_d = ST_IDLE;
        else
          cnt_d = cnt_q - 1'b1;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q  <= ST_IDLE;
      cnt_q <= '0;
      dir_q <= 1'b1;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      dir_q <= dir_d;
    end
  end

  // *****************************************************
  // write path and events
  // *****************************************************
  logic wrOn_d;
  logic mfmPlus_d;
  logic flpWd_d;
  logic [3:0] head;

  assign head = (cfg.head > HEAD_MAX) ? HEAD_MAX : cfg.head;

  // a fault mid-write drops the gate at the next clock edge
  always_comb
  begin
    wrOn_d    = writeReq && ready && !inhibit;
    mfmPlus_d = wrOn_d && !cfg.floppy && writeBit;
    flpWd_d   = !(wrOn_d && cfg.floppy && writeBit);
    idxPrev_d = cfg.floppy ? flpStat.indexN : fixStat.indexN;
    rdPrev_d  = cfg.floppy ? flpReadData : (mfmRdPlus && !mfmRdMinus);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      idxPrev_q     <= 1'b1;
      rdPrev_q      <= 1'b0;
      writeActive   <= 1'b0;
      fixWriteGateN <= 1'b1;
      flpWriteGateN <= 1'b1;
      mfmWrPlus     <= 1'b0;
      mfmWrMinus    <= 1'b1;
      flpWriteDataN <= 1'b1;
      fixStepN      <= 1'b1;
      flpStepN      <= 1'b1;
      fixDirIn      <= 1'b1;
      flpDir        <= 1'b1;
      fixSelectN    <= 2'h3;
      flpSelectN    <= 4'hF;
      fixHeadN      <= 4'hF;
      flpMotorN     <= 1'b1;
      flpSideN      <= 1'b1;
      stepBusy      <= 1'b0;
      driveUsable   <= 1'b0;
      indexPulse    <= 1'b0;
      fluxPulse     <= 1'b0;
      atTrackZero   <= 1'b0;
      faultSeen     <= 1'b0;
    end
    else
    begin
      idxPrev_q     <= idxPrev_d;
      rdPrev_q      <= rdPrev_d;
      writeActive   <= wrOn_d;
      fixWriteGateN <= !(wrOn_d && !cfg.floppy);
      flpWriteGateN <= !(wrOn_d && cfg.floppy);
      mfmWrPlus     <= mfmPlus_d;
      mfmWrMinus    <= !mfmPlus_d;
      flpWriteDataN <= flpWd_d;
      fixStepN      <= !(st_d == ST_PULSE && !cfg.floppy);
      flpStepN      <= !(st_d == ST_PULSE && cfg.floppy);
      fixDirIn      <= dir_d;
      flpDir        <= dir_d;
      // deselecting the fixed drive clears its latched fault
      fixSelectN    <= fixSelAll[1:0];
      flpSelectN    <= sel_decode(cfg.enable && cfg.floppy, cfg.unit);
      fixHeadN      <= ~head;
      flpMotorN     <= !cfg.motorOn;
      flpSideN      <= !cfg.side;
      stepBusy      <= st_d != ST_IDLE;
      driveUsable   <= ready;
      indexPulse    <= idxPrev_q && !idxPrev_d;
      fluxPulse     <= !rdPrev_q && rdPrev_d;
      atTrackZero   <= cfg.floppy ? !flpStat.trackZeroN : !fixStat.trackZeroN;
      faultSeen     <= !cfg.floppy && !fixStat.faultN;
    end
  end

  // *****************************************************
  // checks
  // *****************************************************
  property p_gate_blocked;
    @(posedge clk) disable iff (!resetn)
    (inhibit || !ready) |=> (fixWriteGateN && flpWriteGateN);
  endproperty
  a_gate_blocked: assert property (p_gate_blocked) else $error("write gate while blocked");

  property p_one_select;
    @(posedge clk) disable iff (!resetn)
    $countones({~fixSelectN, ~flpSelectN}) <= 1;
  endproperty
  a_one_select: assert property (p_one_select) else $error("two drives selected");

  property p_step_fault;
    @(posedge clk) disable iff (!resetn)
    (st_q == ST_IDLE && stepReq && inhibit) |=> fixStepN && flpStepN;
  endproperty
  a_step_fault: assert property (p_step_fault) else $error("step under fault");

  property p_mfm_idle;
    @(posedge clk) disable iff (!resetn)
    fixWriteGateN |-> (!mfmWrPlus && mfmWrMinus);
  endproperty
  a_mfm_idle: assert property (p_mfm_idle) else $error("mfm pair not idle");

  property p_index_edge;
    @(posedge clk) disable iff (!resetn)
    (cfg.floppy == $past(cfg.floppy) && !cfg.floppy && $fell(fixStat.indexN)) |=> indexPulse;
  endproperty
  a_index_edge: assert property (p_index_edge) else $error("index edge missed");

  property p_fix_gate;
    @(posedge clk) disable iff (!resetn)
    !fixWriteGateN |-> $past(writeReq && !cfg.floppy);
  endproperty
  a_fix_gate: assert property (p_fix_gate) else $error("fixed gate without request");

  property p_head_code;
    @(posedge clk) disable iff (!resetn)
    ##1 (fixHeadN == ~$past(head));
  endproperty
  a_head_code: assert property (p_head_code) else $error("head lines wrong");

  property p_motor;
    @(posedge clk) disable iff (!resetn)
    cfg.motorOn |=> !flpMotorN;
  endproperty
  a_motor: assert property (p_motor) else $error("motor line wrong");

endmodule // disk_port_ctrl

/* File: verif/drive_model.sv */
// behavioural fixed drive and floppy drive facing the controller
// assumes controller outputs change just after the rising clock edge
`timescale 1ns/1ps
module drive_model #(
  parameter int MY_NUM  = 0,
  parameter int IDX_PER = 40
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  faultIn,
  input  wire logic                  protectIn,
  input  wire logic                  fixStepN,
  input  wire logic                  fixDirIn,
  input  wire logic [1:0]            fixSelectN,
  input  wire logic [3:0]            flpSelectN,
  input  wire logic                  flpMotorN,
  output disk_port_pkg::fixedStat_t  fixStat,
  output disk_port_pkg::floppyStat_t flpStat
);
  import disk_port_pkg::*;
  int   cyl;
  int   settle;
  int   idx;
  logic faultQ;
  logic stepQ;
  // head position, settling time and latched fault
  // non-blocking so the controller never sees status move inside its own edge
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cyl <= 0;
      settle <= 0;
      idx <= 0;
      faultQ <= 0;
      stepQ <= 1;
    end
    else
    begin
      if (stepQ && !fixStepN && !faultQ)
      begin
        cyl <= fixDirIn ? ((cyl > 0) ? cyl - 1 : 0) : cyl + 1;
        settle <= 10;
      end
      else if (settle > 0)
        settle <= settle - 1;
      stepQ <= fixStepN;
      if (faultIn)
        faultQ <= 1;
      else if (&fixSelectN)
        faultQ <= 0;
      idx <= (idx + 1) % IDX_PER; // short revolution keeps the run brief
    end
  end
  // status lines, all active low
  always_comb
  begin
    fixStat.selectedN  = fixSelectN[MY_NUM];
    fixStat.readyN     = fixSelectN[MY_NUM];
    fixStat.seekDoneN  = (settle != 0);
    fixStat.trackZeroN = (cyl != 0);
    fixStat.faultN     = !faultQ;
    fixStat.indexN     = (idx > 1);
    flpStat.readyN     = flpSelectN[0] | flpMotorN;
    flpStat.trackZeroN = 1'b0;
    flpStat.protectN   = !protectIn;
    flpStat.indexN     = (idx > 2);
  end
endmodule // drive_model

/* File: verif/tb_top.sv */
// self-checking bench for the drive-port controller
// assumes drive_model on the far side and the registered timing of the notes
`timescale 1ns/1ps
module tb_top;
  import disk_port_pkg::*;
  logic clk = 0, resetn = 0, stepReq = 0, stepOut = 0, writeReq = 0, writeBit = 0;
  logic faultIn = 0, protectIn = 0, mfmRdPlus = 0, mfmRdMinus = 1, flpReadData = 0;
  logic stepBusy, driveUsable, writeActive, indexPulse, fluxPulse, atTrackZero, faultSeen;
  logic fixWriteGateN, fixStepN, fixDirIn, mfmWrPlus, mfmWrMinus, flpMotorN, flpDir;
  logic flpStepN, flpWriteDataN, flpWriteGateN, flpSideN;
  logic [1:0]  fixSelectN;
  logic [3:0]  fixHeadN, flpSelectN;
  logic [31:0] lfsr = 32'h0000_42a5;
  driveCfg_t   cfg = '0;
  fixedStat_t  fixStat;
  floppyStat_t flpStat;
  int num_errors = 0, checked = 0, cycles = 0, eIdx, gIdx;
  logic prevIdx;
  logic rdOld = 0, rdNow = 0;

  disk_port_ctrl disk_port_ctrl_i (.clk(clk), .resetn(resetn), .cfg(cfg), .stepReq(stepReq),
    .stepOut(stepOut), .writeReq(writeReq), .writeBit(writeBit), .stepBusy(stepBusy),
    .driveUsable(driveUsable), .writeActive(writeActive), .indexPulse(indexPulse),
    .fluxPulse(fluxPulse), .atTrackZero(atTrackZero), .faultSeen(faultSeen),
    .fixStat(fixStat), .fixWriteGateN(fixWriteGateN), .fixStepN(fixStepN),
    .fixDirIn(fixDirIn), .fixSelectN(fixSelectN), .fixHeadN(fixHeadN),
    .mfmWrPlus(mfmWrPlus), .mfmWrMinus(mfmWrMinus), .mfmRdPlus(mfmRdPlus),
    .mfmRdMinus(mfmRdMinus), .flpStat(flpStat), .flpReadData(flpReadData),
    .flpSelectN(flpSelectN), .flpMotorN(flpMotorN), .flpDir(flpDir), .flpStepN(flpStepN),
    .flpWriteDataN(flpWriteDataN), .flpWriteGateN(flpWriteGateN), .flpSideN(flpSideN));
  drive_model #(.MY_NUM(0), .IDX_PER(40)) drive_model_i (.clk(clk), .resetn(resetn),
    .faultIn(faultIn), .protectIn(protectIn), .fixStepN(fixStepN), .fixDirIn(fixDirIn),
    .fixSelectN(fixSelectN), .flpSelectN(flpSelectN), .flpMotorN(flpMotorN),
    .fixStat(fixStat), .flpStat(flpStat));

  // clock and a hang guard well beyond the expected run
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      test_done;
    end
  end

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // random source for read flux, write bits and the head, side and motor settings
  function automatic logic [31:0] lfsrNext(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // one edge, then inputs move 1 ns later; read lines get random flux
  // the read level seen at each edge feeds a reference edge detector
  task automatic tick;
    @(posedge clk);
    rdOld = rdNow;
    rdNow = cfg.floppy ? flpReadData : (mfmRdPlus && !mfmRdMinus);
    #1;
    chk(fluxPulse, !rdOld && rdNow);
    lfsr = lfsrNext(lfsr);
    mfmRdPlus = lfsr[5];
    mfmRdMinus = !lfsr[5];
    flpReadData = lfsr[7];
  endtask
  // reference for select and head lines
  function automatic logic [9:0] expSel(driveCfg_t c);
    logic [1:0] f = 2'b11;
    logic [3:0] p = 4'hf;
    if (c.enable && !c.floppy && c.unit < 2)
      f[c.unit[0]] = 1'b0;
    if (c.enable && c.floppy)
      p[c.unit] = 1'b0;
    return {f, p, ~((c.head > 14) ? 4'he : c.head)};
  endfunction
  // one step request on the port cfg picks; take says whether it may be honoured
  task automatic doStep(logic dir, logic take);
    stepOut = dir;
    stepReq = 1;
    tick;
    stepReq = 0;
    chk({fixStepN, flpStepN}, take ? {cfg.floppy, !cfg.floppy} : 2'b11);
    chk(stepBusy, take);
    if (take)
    begin
      chk({fixDirIn, flpDir}, {dir, dir});
      repeat (3) tick;
      chk(driveUsable, cfg.floppy);
      repeat (STEP_PULSE_CYC - 4) tick;
      chk({fixStepN, flpStepN}, {cfg.floppy, !cfg.floppy});
      tick;
      chk({fixStepN, flpStepN}, 2'b11);
      repeat (STEP_GAP_CYC - 1) tick;
      chk(stepBusy, 1);
      tick;
      chk(stepBusy, 0);
      chk(driveUsable, 1);
    end
  endtask
  // random write bits; gate tells whether writing is allowed
  task automatic doWrite(int n, logic gate);
    writeReq = 1;
    repeat (n)
    begin
      // an encoded flux stream never has two ones in a row, so each one is a fall
      writeBit = lfsr[9] & !writeBit;
      tick;
      chk(writeActive, gate);
      if (cfg.floppy)
      begin
        chk(flpWriteGateN, !gate);
        chk(flpWriteDataN, !(gate & writeBit));
      end
      else
      begin
        chk(fixWriteGateN, !gate);
        chk(mfmWrPlus, gate & writeBit);
      end
    end
    writeReq = 0;
    tick;
    chk({fixWriteGateN, flpWriteGateN, mfmWrPlus, mfmWrMinus}, 4'hd);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    chk({fixWriteGateN, fixStepN, mfmWrMinus, mfmWrPlus}, 4'he);
    #1 resetn = 1;
    for (int k = 0; k < 16; k++)
    begin
      cfg = {k[0], k[2:1], k != 15, lfsr[3:0], lfsr[4], lfsr[6]};
      tick;
      chk({fixSelectN, flpSelectN, fixHeadN}, expSel(cfg));
      chk({flpSideN, flpMotorN}, {!cfg.side, !cfg.motorOn});
    end
    $display("test drive lines done");
    cfg = '0;
    cfg.enable = 1;
    repeat (3) tick;
    chk(atTrackZero, 1);
    doStep(0, 1);
    chk(atTrackZero, 0);
    doStep(1, 1);
    chk(atTrackZero, 1);
    doWrite(8, 1);
    $display("test fixed step and write done");
    eIdx = 0;
    gIdx = 0;
    prevIdx = fixStat.indexN;
    for (int i = 0; i < 202; i++)
    begin
      tick;
      if (i < 200 && prevIdx && !fixStat.indexN)
        eIdx++;
      // a fall seen at tick i shows as a pulse at tick i + 1
      if (i >= 1 && i <= 200 && indexPulse === 1'b1)
        gIdx++;
      prevIdx = fixStat.indexN;
    end
    chk(gIdx, eIdx);
    chk(eIdx, 5);
    $display("test index done");
    faultIn = 1;
    tick;
    faultIn = 0;
    repeat (2) tick;
    chk(faultSeen, 1);
    doStep(0, 0);
    doWrite(3, 0);
    cfg.enable = 0;
    repeat (2) tick;
    cfg.enable = 1;
    repeat (3) tick;
    chk(faultSeen, 0);
    $display("test fault done");
    cfg = {1'b1, 2'b00, 1'b1, 4'h0, 1'b1, 1'b1};
    protectIn = 1;
    repeat (3) tick;
    chk(driveUsable, 1);
    chk(atTrackZero, 1);
    doWrite(3, 0);
    doStep(1, 0);
    protectIn = 0;
    repeat (2) tick;
    doStep(0, 1);
    doWrite(8, 1);
    cfg.motorOn = 0;
    repeat (3) tick;
    chk(driveUsable, 0);
    $display("test floppy done");
    test_done;
  end
endmodule // tb_top
